/* File: analog_fault_indicator.sv */
// What this block does
// - Major faults report 1605/1607/1608, error LED steady, conversion LED dark.
// - Warnings 1801/1802/1807 report codes, conversion LED dark, error LED blinks.
// - Calibration warning 1804 blinks error LED; conversion LED blinks only in RUN.
// - Channel one to eight out of range report 1808 through 180F.
// - Out of range blinks error LED; conversion LED blinks in RUN, dark in STOP.
// - Undetected module: conversion dark, error blinks twice, pauses two seconds, then blinks without end.
// - Warning codes are flagged as warnings so the host keeps running.
// - Host setting promotes the first four warning codes to error severity.
`timescale 1ns/1ps
`include "fault_indicator_map.svh"
module analog_fault_indicator
#(
  parameter int unsigned CHANNELS = 8,
  parameter int unsigned BLINK_HALF_CYC = `BLINK_HALF_CYC,
  parameter int unsigned PAUSE_CYC = `PAUSE_CYC
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic hwFailMajor,
  input wire logic voltFailMajor,
  input wire logic calFailMajor,
  input wire logic voltWarn,
  input wire logic hwWarn,
  input wire logic calWarn,
  input wire logic coldJunctionWarn,
  input wire logic [CHANNELS-1:0] rangeFault,
  input wire logic hostRun,
  input wire logic promoteWarnings,
  input wire logic hostDetected,
  output logic [15:0] errorCode,
  output logic codeIsWarning,
  output logic errorLed,
  output logic convLed
);
  import fault_indicator_pkg::*;
  ind_state_t s_q;
  ind_state_t s_d;
  logic tick;
  logic [15:0] rangeCode;
  logic rangeAny;
  logic [CHANNELS-1:0] lowerHit;
  logic majorAny;
  logic [15:0] majorCodeSel;
  logic warnAny;
  logic [15:0] warnCodeSel;
  logic calShown;
  // ==========================================
  // Blink timebase
  // divided clock
  blink_ticker #(.HALF_CYC(BLINK_HALF_CYC)) u_ticker
  (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .tick(tick)
  );
  // ==========================================
  // Channel scan, lowest channel reported first
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_lower
      if (g == 0)
      begin : g_first
        assign lowerHit[g] = 1'b0;
      end
      else
      begin : g_rest
        assign lowerHit[g] = lowerHit[g-1] | rangeFault[g-1];
      end
    end
  endgenerate
  always_comb
  begin
    rangeCode = `CODE_NONE;
    rangeAny = |rangeFault;
    for (int i = 0; i < CHANNELS; i++)
    begin
      if (rangeFault[i] && !lowerHit[i])
      begin
        rangeCode = `CODE_RANGE_BASE + 16'(i);
      end
    end
  end
  // ==========================================
  // Fault priority decode
  // majors before warnings
  always_comb
  begin
    majorAny = hwFailMajor || voltFailMajor || calFailMajor;
    warnAny = voltWarn || hwWarn || calWarn || coldJunctionWarn;
    calShown = 1'b0;
    majorCodeSel = `CODE_CAL_MAJOR;
    if (hwFailMajor)
    begin
      majorCodeSel = `CODE_HW_MAJOR;
    end
    else if (voltFailMajor)
    begin
      majorCodeSel = `CODE_VOLT_MAJOR;
    end
    warnCodeSel = `CODE_COLD_WARN;
    if (voltWarn)
    begin
      warnCodeSel = `CODE_VOLT_WARN;
    end
    else if (hwWarn)
    begin
      warnCodeSel = `CODE_HW_WARN;
    end
    else if (calWarn)
    begin
      warnCodeSel = `CODE_CAL_WARN;
      calShown = 1'b1;
    end
  end
  // ==========================================
  // Code and LED selection
  always_comb
  begin
    s_d = s_q;
    // Free-running phase shared by every blinking pattern
    if (tick)
    begin
      s_d.blink = !s_q.blink;
    end
    s_d.code = `CODE_NONE;
    s_d.warning = 1'b0;
    s_d.errorLed = 1'b0;
    s_d.convLed = 1'b0;
    // Overrides every code, the host cannot read one anyway
    if (!hostDetected)
    begin
      unique case (s_q.phase)
        PH_SHORT:
        begin
          s_d.errorLed = s_q.blink;
          // Counts lit half-periods, a partial first one included
          if (tick && s_q.blink)
          begin
            s_d.shortCnt = s_q.shortCnt + 4'h1;
            if (s_q.shortCnt + 4'h1 >= 4'(`UNDETECTED_SHORT_BLINKS))
            begin
              s_d.phase = PH_PAUSE;
              s_d.pauseCnt = 32'h0000_0000;
            end
          end
        end
        PH_PAUSE:
        begin
          // Dark pause, blink phase keeps running underneath
          s_d.pauseCnt = s_q.pauseCnt + 32'h0000_0001;
          if (s_q.pauseCnt >= PAUSE_CYC - 1)
          begin
            s_d.phase = PH_REPEAT;
          end
        end
        PH_REPEAT:
        begin
          s_d.errorLed = s_q.blink;
        end
        default:
        begin
          s_d.phase = PH_SHORT;
        end
      endcase
    end
    else
    begin
      s_d.phase = PH_SHORT;
      s_d.shortCnt = 4'h0;
      if (majorAny)
      begin
        s_d.errorLed = 1'b1;
        s_d.code = majorCodeSel;
      end
      else if (warnAny)
      begin
        s_d.errorLed = s_q.blink;
        s_d.warning = !promoteWarnings;
        s_d.code = warnCodeSel;
        s_d.convLed = (calShown && hostRun) ? s_q.blink : 1'b0;
      end
      else if (rangeAny)
      begin
        s_d.errorLed = s_q.blink;
        s_d.convLed = hostRun ? s_q.blink : 1'b0;
        s_d.code = rangeCode;
        s_d.warning = 1'b1;
      end
    end
  end
  // ==========================================
  // State register
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  assign errorCode = s_q.code;
  assign codeIsWarning = s_q.warning;
  assign errorLed = s_q.errorLed;
  assign convLed = s_q.convLed;
endmodule : analog_fault_indicator

/* File: fault_indicator_map.svh */
`ifndef FAULT_INDICATOR_MAP_SVH
`define FAULT_INDICATOR_MAP_SVH
// ==========================================
// Reported codes
`define CODE_NONE 16'h0000
`define CODE_HW_MAJOR 16'h1605
`define CODE_VOLT_MAJOR 16'h1607
`define CODE_CAL_MAJOR 16'h1608
`define CODE_VOLT_WARN 16'h1801
`define CODE_HW_WARN 16'h1802
`define CODE_CAL_WARN 16'h1804
`define CODE_COLD_WARN 16'h1807
`define CODE_RANGE_BASE 16'h1808
// ==========================================
// Timing
`define CLK_PERIOD_NS 4
`define BLINK_HALF_MS 250
`define BLINK_HALF_CYC ((`BLINK_HALF_MS * 1000000) / `CLK_PERIOD_NS)
`define PAUSE_MS 2000
`define PAUSE_CYC ((`PAUSE_MS * 1000000) / `CLK_PERIOD_NS)
`define UNDETECTED_SHORT_BLINKS 2
`endif

/* File: fault_indicator_pkg.sv */
package fault_indicator_pkg;
  typedef enum logic [1:0]
  {
    LED_OFF = 2'b00,
    LED_ON = 2'b01,
    LED_BLINK = 2'b10
  } led_mode_t;
  typedef enum logic [1:0]
  {
    PH_SHORT = 2'b00,
    PH_PAUSE = 2'b01,
    PH_REPEAT = 2'b10
  } undet_phase_t;
  typedef struct packed
  {
    logic [31:0] count;
    logic tick;
  } tick_state_t;
  typedef struct packed
  {
    logic [15:0] code;
    logic warning;
    logic errorLed;
    logic convLed;
    logic blink;
    undet_phase_t phase;
    logic [31:0] pauseCnt;
    logic [3:0] shortCnt;
  } ind_state_t;
endpackage : fault_indicator_pkg

/* File: blink_ticker.sv */
`timescale 1ns/1ps
`include "fault_indicator_map.svh"
module blink_ticker
#(
  parameter int unsigned HALF_CYC = `BLINK_HALF_CYC
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  output logic tick
);
  import fault_indicator_pkg::*;
  tick_state_t s_q;
  tick_state_t s_d;
  // ==========================================
  // Divider
  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.count >= HALF_CYC - 1)
    begin
      s_d.count = 32'h0000_0000;
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.count = s_q.count + 32'h0000_0001;
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  assign tick = s_q.tick;
endmodule : blink_ticker

/* File: fault_indicator_sva.sv */
`timescale 1ns/1ps
// ====================
// Port checker
module fault_indicator_sva
#(
  parameter int unsigned CHANNELS = 8
)
(
  input logic ref_clk,
  input logic rst_b,
  input logic hwFailMajor,
  input logic voltFailMajor,
  input logic calFailMajor,
  input logic voltWarn,
  input logic hwWarn,
  input logic calWarn,
  input logic coldJunctionWarn,
  input logic [CHANNELS-1:0] rangeFault,
  input logic hostRun,
  input logic promoteWarnings,
  input logic hostDetected,
  input logic [15:0] errorCode,
  input logic codeIsWarning,
  input logic errorLed,
  input logic convLed
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  logic noMajor;
  logic quiet;
  assign noMajor = hostDetected & ~(hwFailMajor | voltFailMajor | calFailMajor);
  assign quiet = noMajor & ~(voltWarn | hwWarn | calWarn | coldJunctionWarn);
  a_hw_major:
  assert property (hostDetected && hwFailMajor |=> errorCode == 16'h1605 && errorLed && !convLed)
    else $error("hw major wrong");
  a_cal_major:
  assert property (noMajor == 0 && hostDetected && calFailMajor && !hwFailMajor && !voltFailMajor
    |=> errorCode == 16'h1608 && !codeIsWarning) else $error("cal major wrong");
  a_cold_warn:
  assert property (noMajor && coldJunctionWarn && !voltWarn && !hwWarn && !calWarn
    |=> errorCode == 16'h1807 && codeIsWarning != $past(promoteWarnings))
    else $error("cold warn wrong");
  a_warn_blink:
  assert property ((noMajor && !quiet)[*6] |-> errorLed != $past(errorLed, 4))
    else $error("warn not blinking");
  a_range_last:
  assert property (quiet && rangeFault == 8'h80 |=> errorCode == 16'h180F && codeIsWarning)
    else $error("range code wrong");
  a_stop_dark:
  assert property (!hostRun |=> !convLed) else $error("conv lit in stop");
  a_undet_dark:
  assert property (!hostDetected |=> !convLed) else $error("conv lit undetected");
  a_idle_clear:
  assert property (quiet && rangeFault == '0 |=> errorCode == 16'h0000 && !errorLed)
    else $error("idle not clear");
endmodule : fault_indicator_sva
bind analog_fault_indicator fault_indicator_sva #(.CHANNELS(CHANNELS)) sva (.*);

/* File: host_model.sv */
`timescale 1ns/1ps
// ====================
// Host side
module host_model
(
  input logic runReq,
  input logic [15:0] errorCode,
  input logic codeIsWarning,
  output logic hostRun
);
  assign hostRun = runReq & (codeIsWarning | errorCode == 16'h0000);
endmodule : host_model

/* File: analog_fault_indicator_tb.sv */
`timescale 1ns/1ps
module analog_fault_indicator_tb;
  logic ref_clk = 0;
  logic rst_b = 0;
  logic [6:0] f = 0;
  logic [7:0] rng = 0;
  logic runReq = 1;
  logic pr = 0;
  logic det = 1;
  logic [15:0] code;
  logic warnFlag, eLed, cLed, hostRun, e, c;
  logic [15:0] majorCode [3] = '{16'h1605, 16'h1607, 16'h1608};
  logic [15:0] warnCode [4] = '{16'h1801, 16'h1802, 16'h1804, 16'h1807};
  int fails = 0;
  int compares = 0;
  int dark, maxDark, lit;
  always #2 ref_clk = ~ref_clk;
  host_model host (.runReq(runReq), .errorCode(code), .codeIsWarning(warnFlag),
    .hostRun(hostRun));
  analog_fault_indicator #(.BLINK_HALF_CYC(4), .PAUSE_CYC(20)) dut (.ref_clk(ref_clk),
    .rst_b(rst_b), .hwFailMajor(f[6]), .voltFailMajor(f[5]), .calFailMajor(f[4]),
    .voltWarn(f[3]), .hwWarn(f[2]), .calWarn(f[1]), .coldJunctionWarn(f[0]),
    .rangeFault(rng), .hostRun(hostRun), .promoteWarnings(pr), .hostDetected(det),
    .errorCode(code), .codeIsWarning(warnFlag), .errorLed(eLed), .convLed(cLed));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task hop(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : hop
  task drive(input logic [6:0] nf, input logic [7:0] nr, input logic np);
    f = nf;
    rng = nr;
    pr = np;
    hop(3);
    e = eLed;
    c = cLed;
  endtask : drive
  task report_and_stop;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  task test_major;
    for (int i = 0; i < 3; i++)
    begin
      drive(7'h70 >> i & 7'h70, 8'hFF, 0);
      chk(code, majorCode[i]);
      hop(4);
      chk({eLed, cLed, warnFlag}, 3'b100);
    end
    $display("major test done");
  endtask : test_major
  task test_warn;
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 4; i++)
      begin
        drive(7'h0F >> i, 8'hFF, p[0]);
        chk(code, warnCode[i]);
        chk({warnFlag, hostRun}, {2{~p[0]}});
        hop(4);
        chk({eLed, cLed}, {~e, (i == 2 && p == 0) ? ~c : 1'b0});
      end
    $display("warning test done");
  endtask : test_warn
  task test_range;
    for (int r = 0; r < 2; r++)
      for (int ch = 0; ch < 8; ch++)
      begin
        runReq = r[0];
        drive(0, 8'hFF << ch, r[0]);
        chk(code, 16'h1808 + 16'(ch));
        chk(warnFlag, 1);
        hop(4);
        chk({eLed, cLed}, {~e, r[0] ? ~c : 1'b0});
      end
    runReq = 1;
    $display("range test done");
  endtask : test_range
  task test_undet;
    det = 0;
    drive(7'h7F, 8'hFF, 0);
    dark = 0;
    maxDark = 0;
    lit = 0;
    repeat (80)
    begin
      hop(1);
      chk(cLed, 0);
      lit += eLed;
      dark = eLed ? 0 : dark + 1;
      maxDark = dark > maxDark ? dark : maxDark;
    end
    chk(maxDark >= 20 && maxDark < 40 && lit > 0, 1);
    det = 1;
    drive(0, 0, 0);
    chk(code, 16'h0000);
    chk(eLed, 16'h0000);
    $display("undetected test done");
  endtask : test_undet
  initial
  begin
    #20000;
    fails++;
    report_and_stop();
  end
  initial
  begin
    hop(2);
    rst_b = 1;
    test_major();
    test_warn();
    test_range();
    test_undet();
    report_and_stop();
  end
endmodule : analog_fault_indicator_tb
